// ### hdl/fic_pkg.sv
// Package for the flash identification and secure-ID host controller.
// Assumes a 100 MHz system clock and an x16 asynchronous flash on the pins.
package fic_pkg;
   localparam int CLK_PERIOD_NS = 10;
   // Pin timing, in ns, and derived cycle counts (least times round up)
   localparam int T_SETUP_NS = 40;
   localparam int T_PULSE_NS = 40;
   localparam int T_READ_NS = 70;
   localparam int T_RECOV_NS = 30;
   localparam int T_RESET_NS = 500;
   localparam int SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PULSE_CYC = (T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int READ_CYC = (T_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RECOV_CYC = (T_RECOV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESET_CYC = (T_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 8;
   localparam int ADDR_W = 21;
   localparam int DATA_W = 16;
   // Command addresses and data
   localparam logic [ADDR_W-1:0] CMD_ADDR_1 = 21'h000555;
   localparam logic [ADDR_W-1:0] CMD_ADDR_2 = 21'h0002AA;
   localparam logic [DATA_W-1:0] CMD_UNLOCK_1 = 16'h00AA;
   localparam logic [DATA_W-1:0] CMD_UNLOCK_2 = 16'h0055;
   localparam logic [DATA_W-1:0] CMD_ID_ENTRY = 16'h0090;
   localparam logic [DATA_W-1:0] CMD_SECID_ENTRY = 16'h0088;
   localparam logic [DATA_W-1:0] CMD_SECID_PROG = 16'h00A5;
   localparam logic [DATA_W-1:0] CMD_SECID_LOCK = 16'h0085;
   localparam logic [DATA_W-1:0] CMD_EXIT = 16'h00F0;
   localparam logic [DATA_W-1:0] LOCK_DATA = 16'h0000;
   localparam logic [ADDR_W-1:0] ID_MFR_ADDR = 21'h000000;
   localparam logic [ADDR_W-1:0] ID_DEV_ADDR = 21'h000001;
   localparam logic [ADDR_W-1:0] LOCK_STAT_ADDR = 21'h0000FF;
   localparam logic [ADDR_W-1:0] USER_SEG_FIRST = 21'h000008;
   localparam logic [ADDR_W-1:0] USER_SEG_LAST = 21'h000087;
   localparam int TOGGLE_BIT = 6;
   localparam int LOCK_BIT = 3;
   // Wishbone register word offsets (byte addresses)
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_WDATA = 8'h08;
   localparam logic [7:0] REG_RDATA = 8'h0C;
   localparam logic [7:0] REG_STAT = 8'h10;
   localparam logic [7:0] REG_PINS = 8'h14;
   localparam logic [31:0] PINS_RST = 32'h0000_0001;
   // Operation codes written to CTRL[3:0]
   typedef enum logic [3:0] {
      OP_READ = 4'h0, OP_WRITE = 4'h1, OP_ID_ENTRY = 4'h2, OP_SECID_ENTRY = 4'h3,
      OP_EXIT3 = 4'h4, OP_EXIT1 = 4'h5, OP_SECID_PROG = 4'h6, OP_SECID_LOCK = 4'h7,
      OP_RESET = 4'h8
   } fic_op_t;
endpackage

// ### hdl/fic_cyc_if.sv
// Interface between the sequencer and the pin cycle engine.
// Assumes a single clock shared by both ends.
`timescale 1ns/1ps
interface fic_cyc_if;
   import fic_pkg::*;
   logic req;
   logic wr;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic done;
   logic [DATA_W-1:0] rdata;
   modport seq (output req, output wr, output addr, output wdata, input done, input rdata);
   modport eng (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface

// ### hdl/fic_cycle.sv
// Single pin-level bus cycle engine for the flash: one read or one write per request.
// Assumes the flash pins are wired directly; data pins resolved by the bench.
`timescale 1ns/1ps
module fic_cycle
   import fic_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   fic_cyc_if.eng cyc,
   output logic [ADDR_W-1:0] addr_o,
   input wire logic [DATA_W-1:0] data_io_i,
   output logic [DATA_W-1:0] data_io_o,
   output logic data_io_oe_o,
   output logic ce_n_o,
   output logic oe_n_o,
   output logic we_n_o
);
   typedef enum {S_IDLE, S_SETUP, S_STROBE, S_RECOV} fic_cst_t;
   fic_cst_t st_r;
   logic [CNT_W-1:0] cnt_r;
   logic [DATA_W-1:0] rdata_r;
   logic wr_r;
   logic cnt_zero;
   logic [CNT_W-1:0] strobe_len;
   assign cnt_zero = (cnt_r == '0);
   assign strobe_len = wr_r ? CNT_W'(PULSE_CYC - 1) : CNT_W'(READ_CYC - 1);
   assign cyc.rdata = rdata_r;
   assign cyc.done = (st_r == S_RECOV) && cnt_zero;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r <= S_IDLE;
         cnt_r <= '0;
         wr_r <= 1'b0;
         rdata_r <= '0;
         addr_o <= '0;
         data_io_o <= '0;
         data_io_oe_o <= 1'b0;
         ce_n_o <= 1'b1;
         oe_n_o <= 1'b1;
         we_n_o <= 1'b1;
      end else begin
         case (st_r)
            S_IDLE: begin
               if (cyc.req) begin
                  // Address and data are set up with chip enable before the strobe
                  addr_o <= cyc.addr;
                  data_io_o <= cyc.wdata;
                  data_io_oe_o <= cyc.wr;
                  wr_r <= cyc.wr;
                  ce_n_o <= 1'b0;
                  cnt_r <= CNT_W'(SETUP_CYC - 1);
                  st_r <= S_SETUP;
               end
            end
            S_SETUP: begin
               if (cnt_zero) begin
                  // Never both strobes low: read is OE low WE high, write the reverse
                  oe_n_o <= wr_r;
                  we_n_o <= !wr_r;
                  cnt_r <= strobe_len;
                  st_r <= S_STROBE;
               end else begin
                  cnt_r <= cnt_r - 1'b1;
               end
            end
            S_STROBE: begin
               if (cnt_zero) begin
                  if (!wr_r) begin
                     rdata_r <= data_io_i;
                  end
                  oe_n_o <= 1'b1;
                  we_n_o <= 1'b1;
                  cnt_r <= CNT_W'(RECOV_CYC - 1);
                  st_r <= S_RECOV;
               end else begin
                  cnt_r <= cnt_r - 1'b1;
               end
            end
            S_RECOV: begin
               // Data is released only after WE rises, so the flash latches it cleanly
               data_io_oe_o <= 1'b0;
               ce_n_o <= 1'b1;
               if (cnt_zero) begin
                  st_r <= S_IDLE;
               end else begin
                  cnt_r <= cnt_r - 1'b1;
               end
            end
            default: st_r <= S_IDLE;
         endcase
      end
   end
endmodule

// ### hdl/fic_host.sv
// Host controller for an x16 parallel NOR flash: identification, secure-ID query,
// secure-ID programming and lock-out, driven by registers over classic Wishbone.
// Assumes the flash pins attach directly and the bench resolves the data lines.
`timescale 1ns/1ps
// Summary of operation
// - Exit command returns device to array read
// - User segment programmed by dedicated command only
// - Secure-ID program completion polled by toggle bit
// - Lock user segment after programming it
// - Query entry: three writes, last 88H at 555H
// - Leave secure-ID mode with exit command
module fic_host
   import fic_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic [ADDR_W-1:0] addr_o,
   input wire logic [DATA_W-1:0] data_io_i,
   output logic [DATA_W-1:0] data_io_o,
   output logic data_io_oe_o,
   output logic ce_n_o,
   output logic oe_n_o,
   output logic we_n_o,
   output logic wp_n_o,
   output logic rst_n_o
);
   typedef enum {
      H_IDLE, H_ISSUE, H_WAIT, H_POLL_A, H_POLL_B, H_RESET
   } fic_hst_t;

   fic_cyc_if cyc ();
   fic_hst_t st_r;
   logic [2:0] step_r;
   logic [2:0] nsteps_r;
   logic [3:0] op_r;
   logic [ADDR_W-1:0] tgt_addr_r;
   logic [DATA_W-1:0] tgt_data_r;
   logic [DATA_W-1:0] rdata_r;
   logic [DATA_W-1:0] poll_r;
   logic busy_r;
   logic done_r;
   logic err_r;
   logic poll_en_r;
   logic wp_n_r;
   logic [CNT_W-1:0] rcnt_r;
   logic ack_r;
   logic req_r;
   logic wr_r;
   logic [ADDR_W-1:0] caddr_r;
   logic [DATA_W-1:0] cdata_r;

   // Register decode
   logic bus_req;
   logic wr_ctrl;
   logic wr_addr;
   logic wr_wdata;
   logic wr_pins;
   logic start_ok;
   logic [31:0] rd_mux;
   logic user_addr_ok;
   logic op_bad;
   logic [ADDR_W-1:0] step_addr;
   logic [DATA_W-1:0] step_data;
   logic step_is_wr;
   logic last_step;
   logic [DATA_W-1:0] cmd_code;

   assign bus_req = wb_cyc_i && wb_stb_i && !ack_r;
   assign wr_ctrl = bus_req && wb_we_i && (wb_adr_i == REG_CTRL) && wb_sel_i[0];
   assign wr_addr = bus_req && wb_we_i && (wb_adr_i == REG_ADDR);
   assign wr_wdata = bus_req && wb_we_i && (wb_adr_i == REG_WDATA);
   assign wr_pins = bus_req && wb_we_i && (wb_adr_i == REG_PINS) && wb_sel_i[0];
   assign start_ok = wr_ctrl && !busy_r;
   // Only user-segment words are legal for the secure-ID program
   assign user_addr_ok = (wb_adr_i == REG_CTRL) && (tgt_addr_r >= USER_SEG_FIRST)
      && (tgt_addr_r <= USER_SEG_LAST);
   assign op_bad = (wb_dat_i[3:0] == OP_SECID_PROG) && !user_addr_ok;

   always_comb begin
      case (wb_adr_i)
         REG_CTRL: rd_mux = {28'h0000000, op_r};
         REG_ADDR: rd_mux = {11'h000, tgt_addr_r};
         REG_WDATA: rd_mux = {16'h0000, tgt_data_r};
         REG_RDATA: rd_mux = {16'h0000, rdata_r};
         REG_STAT: rd_mux = {28'h0000000, !rdata_r[LOCK_BIT], err_r, done_r, busy_r};
         REG_PINS: rd_mux = {31'h00000000, wp_n_r};
         default: rd_mux = 32'h00000000;
      endcase
   end

   // Command word per step: unlock pair, then code, then optional target write
   always_comb begin
      case (op_r)
         OP_ID_ENTRY: cmd_code = CMD_ID_ENTRY;
         OP_SECID_ENTRY: cmd_code = CMD_SECID_ENTRY;
         OP_SECID_PROG: cmd_code = CMD_SECID_PROG;
         OP_SECID_LOCK: cmd_code = CMD_SECID_LOCK;
         default: cmd_code = CMD_EXIT;
      endcase
   end

   always_comb begin
      step_is_wr = 1'b1;
      if (op_r == OP_EXIT1) begin
         step_addr = tgt_addr_r;
         step_data = CMD_EXIT;
      end else if (op_r == OP_READ || op_r == OP_WRITE) begin
         step_addr = tgt_addr_r;
         step_data = tgt_data_r;
         step_is_wr = (op_r == OP_WRITE);
      end else begin
         case (step_r)
            3'd0: begin
               step_addr = CMD_ADDR_1;
               step_data = CMD_UNLOCK_1;
            end
            3'd1: begin
               step_addr = CMD_ADDR_2;
               step_data = CMD_UNLOCK_2;
            end
            3'd2: begin
               step_addr = CMD_ADDR_1;
               step_data = cmd_code;
            end
            default: begin
               step_addr = tgt_addr_r;
               step_data = (op_r == OP_SECID_LOCK) ? LOCK_DATA : tgt_data_r;
            end
         endcase
      end
   end
   assign last_step = (step_r == nsteps_r - 3'd1);

   assign cyc.req = req_r;
   assign cyc.wr = wr_r;
   assign cyc.addr = caddr_r;
   assign cyc.wdata = cdata_r;
   assign wb_ack_o = ack_r;
   assign wp_n_o = wp_n_r;

   fic_cycle u_cycle (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .cyc(cyc),
      .addr_o(addr_o),
      .data_io_i(data_io_i),
      .data_io_o(data_io_o),
      .data_io_oe_o(data_io_oe_o),
      .ce_n_o(ce_n_o),
      .oe_n_o(oe_n_o),
      .we_n_o(we_n_o)
   );

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         wb_dat_o <= '0;
         tgt_addr_r <= '0;
         tgt_data_r <= '0;
         wp_n_r <= PINS_RST[0];
      end else begin
         ack_r <= bus_req;
         if (bus_req) begin
            wb_dat_o <= rd_mux;
         end
         if (wr_addr) begin
            tgt_addr_r <= wb_dat_i[ADDR_W-1:0];
         end
         if (wr_wdata) begin
            tgt_data_r <= wb_dat_i[DATA_W-1:0];
         end
         if (wr_pins) begin
            wp_n_r <= wb_dat_i[0];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r <= H_IDLE;
         step_r <= '0;
         nsteps_r <= '0;
         op_r <= '0;
         rdata_r <= '0;
         poll_r <= '0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
         err_r <= 1'b0;
         poll_en_r <= 1'b0;
         rcnt_r <= '0;
         req_r <= 1'b0;
         wr_r <= 1'b0;
         caddr_r <= '0;
         cdata_r <= '0;
         rst_n_o <= 1'b0;
      end else begin
         case (st_r)
            H_IDLE: begin
               rst_n_o <= 1'b1;
               if (start_ok) begin
                  op_r <= wb_dat_i[3:0];
                  step_r <= '0;
                  done_r <= 1'b0;
                  err_r <= op_bad;
                  // Program ops wait on the toggle bit; polarity of bit 7 is not trusted
                  poll_en_r <= (wb_dat_i[3:0] == OP_SECID_PROG)
                     || (wb_dat_i[3:0] == OP_SECID_LOCK);
                  case (wb_dat_i[3:0])
                     OP_READ, OP_WRITE, OP_EXIT1: nsteps_r <= 3'd1;
                     OP_SECID_PROG, OP_SECID_LOCK: nsteps_r <= 3'd4;
                     default: nsteps_r <= 3'd3;
                  endcase
                  if (op_bad) begin
                     done_r <= 1'b1;
                  end else if (wb_dat_i[3:0] == OP_RESET) begin
                     busy_r <= 1'b1;
                     rst_n_o <= 1'b0;
                     rcnt_r <= CNT_W'(RESET_CYC - 1);
                     st_r <= H_RESET;
                  end else begin
                     busy_r <= 1'b1;
                     st_r <= H_ISSUE;
                  end
               end
            end
            H_ISSUE: begin
               req_r <= 1'b1;
               wr_r <= step_is_wr;
               caddr_r <= step_addr;
               cdata_r <= step_data;
               st_r <= H_WAIT;
            end
            H_WAIT: begin
               req_r <= 1'b0;
               if (cyc.done) begin
                  if (!last_step) begin
                     step_r <= step_r + 3'd1;
                     st_r <= H_ISSUE;
                  end else if (poll_en_r) begin
                     // First poll read only seeds the compare; a stale sample could end early
                     poll_en_r <= 1'b0;
                     st_r <= H_POLL_A;
                  end else begin
                     if (!wr_r) begin
                        rdata_r <= cyc.rdata;
                     end
                     busy_r <= 1'b0;
                     done_r <= 1'b1;
                     st_r <= H_IDLE;
                  end
               end
            end
            H_POLL_A: begin
               req_r <= 1'b1;
               wr_r <= 1'b0;
               st_r <= H_POLL_B;
            end
            H_POLL_B: begin
               req_r <= 1'b0;
               if (cyc.done) begin
                  poll_r <= cyc.rdata;
                  // Two equal reads of the toggle bit mean the program finished
                  if (poll_en_r && (cyc.rdata[TOGGLE_BIT] == poll_r[TOGGLE_BIT])) begin
                     rdata_r <= cyc.rdata;
                     busy_r <= 1'b0;
                     done_r <= 1'b1;
                     st_r <= H_IDLE;
                  end else begin
                     poll_en_r <= 1'b1;
                     st_r <= H_POLL_A;
                  end
               end
            end
            H_RESET: begin
               if (rcnt_r == '0) begin
                  rst_n_o <= 1'b1;
                  busy_r <= 1'b0;
                  done_r <= 1'b1;
                  st_r <= H_IDLE;
               end else begin
                  rcnt_r <= rcnt_r - 1'b1;
               end
            end
            default: st_r <= H_IDLE;
         endcase
      end
   end
endmodule

// ### bench/fic_flash_model.sv
// Behavioural model of the x16 flash seen from its pins: ID, secure-ID and lock-out.
// Assumes the bench resolves the data lines and holds the strobes high at start.
`timescale 1ns/1ps
module fic_flash_model
   import fic_pkg::*;
#(
   parameter logic [15:0] MFR_CODE = 16'h00C3, // Arbitrary value
   parameter logic [15:0] DEV_CODE = 16'h7E21 // Arbitrary value
) (
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] data_i,
   output logic [DATA_W-1:0] data_o,
   output logic data_oe_o,
   input wire logic ce_n_i,
   input wire logic oe_n_i,
   input wire logic we_n_i,
   input wire logic rst_n_i
);
   logic [1:0] mode_r = 2'd0;
   logic [1:0] step_r = 2'd0;
   logic [7:0] pend_r = 8'h00;
   logic locked_r = 1'b0;
   logic tog_r = 1'b0;
   int busy_r = 0;
   logic [15:0] user_r [8:135];
   initial for (int i = 8; i < 136; i++) user_r[i] = 16'hFFFF;
   // Array is read-only: no erase, so no sector or block select
   always @(negedge we_n_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mode_r = 2'd0;
         step_r = 2'd0;
         pend_r = 8'h00;
         busy_r = 0;
      end else if (!ce_n_i && oe_n_i) begin
         if (pend_r == CMD_SECID_PROG[7:0]) begin
            // Factory words and a locked segment stay as they are
            if (!locked_r && addr_i >= 8 && addr_i <= 135) begin
               user_r[addr_i[7:0]] = user_r[addr_i[7:0]] & data_i;
            end
            pend_r = 8'h00;
            busy_r = 3;
         end else if (pend_r == CMD_SECID_LOCK[7:0]) begin
            locked_r = 1'b1;
            pend_r = 8'h00;
            busy_r = 3;
         end else if (data_i[7:0] == CMD_EXIT[7:0] && step_r != 2'd1) begin
            if (busy_r == 0) mode_r = 2'd0;
            step_r = 2'd0;
         end else if (step_r == 2'd0 && addr_i[10:0] == CMD_ADDR_1[10:0]
                      && data_i[7:0] == CMD_UNLOCK_1[7:0]) begin
            step_r = 2'd1;
         end else if (step_r == 2'd1 && addr_i[10:0] == CMD_ADDR_2[10:0]
                      && data_i[7:0] == CMD_UNLOCK_2[7:0]) begin
            step_r = 2'd2;
         end else begin
            if (step_r == 2'd2 && addr_i[10:0] == CMD_ADDR_1[10:0]) begin
               if (data_i[7:0] == CMD_ID_ENTRY[7:0]) mode_r = 2'd1;
               if (data_i[7:0] == CMD_SECID_ENTRY[7:0]) mode_r = 2'd2;
               if (data_i[7:0] inside {CMD_SECID_PROG[7:0], CMD_SECID_LOCK[7:0]}) begin
                  pend_r = data_i[7:0];
               end
            end
            step_r = 2'd0;
         end
      end
   end
   always @(negedge oe_n_i) begin
      if (!ce_n_i && busy_r > 0) begin
         tog_r = ~tog_r;
         busy_r = busy_r - 1;
      end
   end
   assign data_oe_o = !ce_n_i && !oe_n_i && rst_n_i;
   always @* begin
      // Bit 7 reads 0 while busy, so a host relying on it would misjudge
      if (busy_r > 0) data_o = 16'(tog_r) << TOGGLE_BIT;
      else if (mode_r == 2'd1) data_o = addr_i[0] ? DEV_CODE : MFR_CODE;
      else if (mode_r == 2'd2 && addr_i[7:0] == 8'hFF) data_o = {12'h000, !locked_r, 3'b000};
      else if (mode_r == 2'd2 && addr_i < 8) data_o = 16'h9E00 | addr_i[15:0];
      else if (mode_r == 2'd2 && addr_i <= 135) data_o = user_r[addr_i[7:0]];
      else data_o = addr_i[15:0] ^ 16'hC33C;
   end
endmodule

// ### bench/fic_host_checker.sv
// Pin-level assertions for the flash host controller.
// Assumes it is bound to the controller top and sees its ports only.
`timescale 1ns/1ps
module fic_host_checker
   import fic_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [ADDR_W-1:0] addr_o,
   input wire logic [DATA_W-1:0] data_io_o,
   input wire logic data_io_oe_o,
   input wire logic ce_n_o,
   input wire logic oe_n_o,
   input wire logic we_n_o,
   input wire logic rst_n_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_no_read_write: assert property (!(!oe_n_o && !we_n_o))
      else $error("oe and we low together");
   a_drive_only_write: assert property (data_io_oe_o |-> !ce_n_o && oe_n_o)
      else $error("data driven while flash may drive");
   a_we_needs_ce: assert property (!we_n_o |-> !ce_n_o)
      else $error("write strobe without chip enable");
   a_oe_needs_ce: assert property (!oe_n_o |-> !ce_n_o)
      else $error("output enable without chip enable");
   a_write_pulse_len: assert property ($fell(we_n_o) |-> !we_n_o [*4] ##1 we_n_o)
      else $error("write strobe length wrong");
   a_read_pulse_len: assert property ($fell(oe_n_o) |-> !oe_n_o [*7] ##1 oe_n_o)
      else $error("read strobe length wrong");
   a_addr_held: assert property ((!we_n_o || !oe_n_o) |-> $stable(addr_o))
      else $error("address moved during strobe");
   a_data_held: assert property (!we_n_o |-> data_io_oe_o && $stable(data_io_o))
      else $error("write data not held");
   a_reset_pulse: assert property ($fell(rst_n_o) |-> !rst_n_o [*8])
      else $error("flash reset pulse too short");
   c_write: cover property ($fell(we_n_o));
   c_read: cover property ($fell(oe_n_o));
   c_reset: cover property ($fell(rst_n_o));
endmodule
bind fic_host fic_host_checker chk_i (.clk_i(clk_i), .rst_i(rst_i), .addr_o(addr_o),
   .data_io_o(data_io_o), .data_io_oe_o(data_io_oe_o), .ce_n_o(ce_n_o),
   .oe_n_o(oe_n_o), .we_n_o(we_n_o), .rst_n_o(rst_n_o));

// ### bench/fic_host_tb.sv
// Self-checking bench: Wishbone register sequences against the flash model.
// Assumes the controller answers each Wishbone request and polls status itself.
`timescale 1ns/1ps
module fic_host_tb
   import fic_pkg::*;
;
   localparam logic [15:0] MFR = 16'h00C3;
   localparam logic [15:0] DEV = 16'h7E21;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc = 1'b0;
   logic wb_stb = 1'b0;
   logic wb_we = 1'b0;
   logic [7:0] wb_adr = 8'h00;
   logic [3:0] wb_sel = 4'h0;
   logic [31:0] wb_dat = 32'h0;
   logic [31:0] wb_dat_o;
   logic [31:0] r;
   logic wb_ack;
   logic [ADDR_W-1:0] addr_o;
   logic [DATA_W-1:0] data_io_i;
   logic [DATA_W-1:0] data_io_o;
   logic [DATA_W-1:0] fl_dq;
   logic data_io_oe_o, ce_n_o, oe_n_o, we_n_o, wp_n_o, rst_n_o, fl_oe;
   int rst_lows = 0;
   int lows0 = 0;
   int fails = 0;
   int checks_done = 0;
   initial forever #5 clk_i = ~clk_i;
   // Undriven lines show a pattern that flips at each clock edge, never the last value
   assign data_io_i = fl_oe ? fl_dq : (data_io_oe_o ? data_io_o : {16{clk_i}} ^ 16'h5A5A);
   // Counts edges with the flash reset low; the first edge after release counts once
   always @(posedge clk_i) if (!rst_i && rst_n_o === 1'b0) rst_lows <= rst_lows + 1;
   fic_host uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack), .addr_o(addr_o), .data_io_i(data_io_i),
      .data_io_o(data_io_o), .data_io_oe_o(data_io_oe_o), .ce_n_o(ce_n_o),
      .oe_n_o(oe_n_o), .we_n_o(we_n_o), .wp_n_o(wp_n_o), .rst_n_o(rst_n_o));
   fic_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) fl (.addr_i(addr_o),
      .data_i(data_io_o), .data_o(fl_dq), .data_oe_o(fl_oe), .ce_n_i(ce_n_o),
      .oe_n_i(oe_n_o), .we_n_i(we_n_o), .rst_n_i(rst_n_o));
   function automatic logic [15:0] arr(input logic [ADDR_W-1:0] a);
      return a[15:0] ^ 16'hC33C;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("BAD at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      int n;
      n = 0;
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_dat <= dat;
      wb_sel <= 4'hF;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack !== 1'b1 && n < 50);
      if (wb_ack !== 1'b1) begin
         fails++;
         $display("BAD at %0t: no bus acknowledge", $time);
      end
      r = wb_dat_o;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic run_op(input fic_op_t op);
      int n;
      n = 0;
      xfer(1'b1, REG_CTRL, {28'h0, op});
      do begin
         xfer(1'b0, REG_STAT, 32'h0);
         n++;
      end while ((r[0] !== 1'b0 || r[1] !== 1'b1) && n < 200);
      if (r[0] !== 1'b0 || r[1] !== 1'b1) begin
         fails++;
         $display("BAD at %0t: operation never finished", $time);
      end
   endtask
   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [15:0] e);
      xfer(1'b1, REG_ADDR, 32'(a));
      run_op(OP_READ);
      xfer(1'b0, REG_RDATA, 32'h0);
      chk(r, {16'h0000, e});
   endtask
   task automatic prog(input logic [ADDR_W-1:0] a, input logic [15:0] d);
      xfer(1'b1, REG_ADDR, 32'(a));
      xfer(1'b1, REG_WDATA, {16'h0000, d});
      run_op(OP_SECID_PROG);
   endtask
   task automatic summarize;
      $display("checks %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Whole run is a few thousand cycles; this bound leaves a wide margin
   initial begin
      #500000;
      fails++;
      summarize();
   end
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk({31'h0, wp_n_o}, 32'h1);
      xfer(1'b0, REG_PINS, 32'h0);
      chk(r, PINS_RST);
      xfer(1'b0, 8'h20, 32'h0);
      chk(r, 32'h0);
      rd_chk(21'h000123, arr(21'h000123));
      run_op(OP_ID_ENTRY);
      rd_chk(ID_MFR_ADDR, MFR);
      rd_chk(ID_DEV_ADDR, DEV);
      run_op(OP_EXIT3);
      rd_chk(ID_MFR_ADDR, arr(ID_MFR_ADDR));
      run_op(OP_ID_ENTRY);
      xfer(1'b1, REG_ADDR, 32'h777);
      run_op(OP_EXIT1);
      rd_chk(ID_DEV_ADDR, arr(ID_DEV_ADDR));
      run_op(OP_ID_ENTRY);
      rd_chk(ID_DEV_ADDR, DEV);
      xfer(1'b1, REG_WDATA, {16'h0000, CMD_EXIT});
      run_op(OP_WRITE);
      rd_chk(ID_MFR_ADDR, arr(ID_MFR_ADDR));
      // A start while busy is dropped, so the flash stays in array read
      xfer(1'b1, REG_ADDR, 32'h2);
      xfer(1'b1, REG_CTRL, {28'h0, OP_READ});
      run_op(OP_ID_ENTRY);
      rd_chk(21'h000003, arr(21'h000003));
      run_op(OP_SECID_ENTRY);
      for (int i = 0; i < 8; i++) rd_chk(21'(i), 16'h9E00 | 16'(i));
      rd_chk(LOCK_STAT_ADDR, 16'h0008);
      xfer(1'b0, REG_STAT, 32'h0);
      chk({31'h0, r[3]}, 32'h0);
      prog(USER_SEG_FIRST, 16'h1234);
      rd_chk(USER_SEG_FIRST, 16'h1234);
      prog(USER_SEG_LAST, 16'hBEEF);
      rd_chk(USER_SEG_LAST, 16'hBEEF);
      prog(21'h000088, 16'h0000);
      chk({31'h0, r[2]}, 32'h1);
      prog(21'h000007, 16'h0000);
      chk({31'h0, r[2]}, 32'h1);
      rd_chk(21'h000007, 16'h9E07);
      run_op(OP_SECID_LOCK);
      rd_chk(LOCK_STAT_ADDR, 16'h0000);
      xfer(1'b0, REG_STAT, 32'h0);
      chk({31'h0, r[3]}, 32'h1);
      prog(21'h000009, 16'h0000);
      rd_chk(21'h000009, 16'hFFFF);
      run_op(OP_EXIT3);
      rd_chk(USER_SEG_FIRST, arr(USER_SEG_FIRST));
      xfer(1'b1, REG_PINS, 32'h0);
      chk({31'h0, wp_n_o}, 32'h0);
      xfer(1'b1, REG_PINS, PINS_RST);
      run_op(OP_ID_ENTRY);
      lows0 = rst_lows;
      run_op(OP_RESET);
      chk(32'(rst_lows - lows0), 32'(RESET_CYC));
      rd_chk(ID_MFR_ADDR, arr(ID_MFR_ADDR));
      summarize();
   end
endmodule
